// *** dalcmp_defines.svh ***
// register indices, field positions, reset values and bus codes of the alarm block
`ifndef DALCMP_DEFINES_SVH
`define DALCMP_DEFINES_SVH

// register indices; byte address is four times the index
`define DALCMP_IDX_CTRL       6'h07
`define DALCMP_IDX_A0_SEC     6'h0A
`define DALCMP_IDX_A0_MIN     6'h0B
`define DALCMP_IDX_A0_HOUR    6'h0C
`define DALCMP_IDX_A0_WKDAY   6'h0D
`define DALCMP_IDX_A0_DATE    6'h0E
`define DALCMP_IDX_A0_MTH     6'h0F
`define DALCMP_IDX_A1_SEC     6'h11
`define DALCMP_IDX_A1_MIN     6'h12
`define DALCMP_IDX_A1_HOUR    6'h13
`define DALCMP_IDX_A1_WKDAY   6'h14
`define DALCMP_IDX_A1_DATE    6'h15
`define DALCMP_IDX_A1_MTH     6'h16

// weekday/hours/control register fields
`define DALCMP_WK_POL_BIT     7
`define DALCMP_WK_SEL_HI      6
`define DALCMP_WK_SEL_LO      4
`define DALCMP_WK_FLAG_BIT    3
`define DALCMP_HR_FMT_BIT     6
`define DALCMP_HR_PM_BIT      5
`define DALCMP_CTRL_GPO_BIT   7
`define DALCMP_CTRL_SQW_BIT   6
`define DALCMP_CTRL_EN1_BIT   5
`define DALCMP_CTRL_EN0_BIT   4

// reset values
`define DALCMP_RST_WKDAY      3'h1
`define DALCMP_RST_DATE       6'h01
`define DALCMP_RST_MTH        5'h01
`define DALCMP_RST_GPO        1'b1

// bus response codes
`define DALCMP_RESP_OKAY      2'h0
`define DALCMP_RESP_SLVERR    2'h2

`endif

// *** dalcmp_pkg.sv ***
// types shared by the dual alarm comparator
package dalcmp_pkg;

   typedef logic [7:0] dalcmp_byte_t;

   typedef enum logic [2:0]
   {
      DALCMP_SEL_SEC   = 3'b000,
      DALCMP_SEL_MIN   = 3'b001,
      DALCMP_SEL_HOUR  = 3'b010,
      DALCMP_SEL_WKDAY = 3'b011,
      DALCMP_SEL_DATE  = 3'b100,
      DALCMP_SEL_RSV5  = 3'b101,
      DALCMP_SEL_RSV6  = 3'b110,
      DALCMP_SEL_ALL   = 3'b111
   } dalcmp_match_sel_t;

   typedef enum logic [1:0]
   {
      DALCMP_OUT_GPO   = 2'b00,
      DALCMP_OUT_ALARM = 2'b01,
      DALCMP_OUT_SQW   = 2'b10
   } dalcmp_out_mode_t;

endpackage

// *** dalcmp_tb.sv ***
// self-checking bench for the dual alarm comparator
`include "dalcmp_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dalcmp_pkg::*;

   logic              mclk, nrst, sq_lvl;
   logic              aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
   logic              ar_valid, ar_ready, r_valid, r_ready, pin_o, pin_oe;
   logic [7:0]        aw_addr, ar_addr;
   logic [31:0]       w_data, r_data, rd;
   logic [3:0]        w_strb;
   logic [1:0]        b_resp, r_resp, rsp, flags;
   dalcmp_byte_t      cur_s, cur_m, cur_h, cur_w, cur_d, cur_mo;
   dalcmp_byte_t      mv [6];
   logic [2:0]        codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   logic [7:0]        msk [6] = '{8'h7F, 8'h7F, 8'h3F, 8'hF7, 8'h3F, 8'h1F};
   int                seed = 41;
   int                n_errors = 0;
   int                comparisons = 0;

   dalcmp_top dalcmp_top_inst
   (
      .mclk(mclk), .nrst(nrst),
      .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
      .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
      .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
      .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
      .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
      .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
      .cur_seconds(cur_s), .cur_minutes(cur_m), .timekeeping_hours_reg(cur_h),
      .cur_weekday(cur_w), .cur_date(cur_d), .cur_month(cur_mo),
      .square_wave_level(sq_lvl), .alarm_match_flag(flags),
      .multi_function_pin_o(pin_o), .multi_function_pin_oe(pin_oe)
   );

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // master holds each channel until its own ready, bready until bvalid
   task automatic wr(input logic [5:0] idx, input logic [7:0] val);
      @(posedge mclk);
      aw_addr <= {idx, 2'b00};
      w_data <= {24'h0, val};
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge mclk);
         if (aw_ready)
            aw_valid <= 1'b0;
         if (w_ready)
            w_valid <= 1'b0;
         if (b_valid)
         begin
            rsp = b_resp;
            b_ready <= 1'b0;
            return;
         end
      end
      n_errors++;
      give_verdict();
   endtask

   task automatic rdreg(input logic [5:0] idx);
      @(posedge mclk);
      ar_addr <= {idx, 2'b00};
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge mclk);
         if (ar_ready)
            ar_valid <= 1'b0;
         if (r_valid)
         begin
            rd = r_data;
            rsp = r_resp;
            r_ready <= 1'b0;
            return;
         end
      end
      n_errors++;
      give_verdict();
   endtask

   task automatic expect_reg(input logic [5:0] idx, input logic [7:0] exp);
      rdreg(idx);
      check("register read", rd, {24'h0, exp});
      check("read response", rsp, `DALCMP_RESP_OKAY);
   endtask

   // idle values are invalid bcd, or weekday 0, so they cannot match
   task automatic put_time(input logic [5:0] m);
      @(posedge mclk);
      cur_s <= m[0] ? mv[0] : 8'h7F;
      cur_m <= m[1] ? mv[1] : 8'h7F;
      cur_h <= m[2] ? mv[2] : 8'h3F;
      cur_w <= m[3] ? mv[3] : 8'h00;
      cur_d <= m[4] ? mv[4] : 8'h3F;
      cur_mo <= m[5] ? mv[5] : 8'h1F;
   endtask

   function automatic logic [7:0] bcd(input int tmax);
      int t;
      int o;
      t = $unsigned($random(seed)) % (tmax + 1);
      o = $unsigned($random(seed)) % 10;
      return 8'(t * 16 + o);
   endfunction

   function automatic logic [7:0] gen(input int k);
      logic [7:0] r;
      r = 8'($random(seed));
      case (k)
         0, 1: return bcd(5) | {r[7], 7'h0};
         2: return bcd(2) | {r[7], 7'h0};
         3: return {r[7], codes[$unsigned($random(seed)) % 6], r[3], 3'(1 + r[6:4] % 7)};
         4: return bcd(3) | {r[7:6], 6'h0};
         default: return bcd(1) | {r[7:5], 5'h0};
      endcase
   endfunction

   function automatic logic exp_flag(input logic [2:0] sel, input logic [5:0] m);
      case (sel)
         3'h0, 3'h1, 3'h2, 3'h3, 3'h4: return m[sel];
         3'h7: return &m;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic exp_pin(input logic [1:0] en, input logic pol,
                                    input logic [1:0] f, input logic gp);
      if (en == 2'b00)
         return gp;
      if (pol)
         return |(f & en);
      return ~&(f | ~en);
   endfunction

   initial
   begin
      logic [5:0] base;
      logic [7:0] v;
      int         u;
      int         k;
      nrst = 1'b0;
      {aw_valid, w_valid, b_ready, ar_valid, r_ready, sq_lvl} = '0;
      aw_addr = '0;
      ar_addr = '0;
      w_data = '0;
      w_strb = 4'hF;
      mv = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
      {cur_s, cur_m, cur_h, cur_w, cur_d, cur_mo} = {8'h7F, 8'h7F, 8'h3F, 8'h00, 8'h3F, 8'h1F};
      tick(3);
      nrst <= 1'b1;
      expect_reg(`DALCMP_IDX_CTRL, 8'h80);
      for (u = 0; u < 2; u++)
      begin
         base = u ? `DALCMP_IDX_A1_SEC : `DALCMP_IDX_A0_SEC;
         for (k = 0; k < 6; k++)
            expect_reg(base + 6'(k), k > 2 ? 8'h01 : 8'h00);
      end
      check("flags after reset", flags, 2'b00);
      check("pin after reset", pin_oe, 1'b0);
      check("pin data", pin_o, 1'b0);
      // random register traffic; unimplemented bits must read zero
      repeat (30)
      begin
         u = $unsigned($random(seed)) % 2;
         k = $unsigned($random(seed)) % 6;
         base = u ? `DALCMP_IDX_A1_SEC : `DALCMP_IDX_A0_SEC;
         v = gen(k);
         wr(base + 6'(k), v);
         check("write response", rsp, `DALCMP_RESP_OKAY);
         expect_reg(base + 6'(k), v & msk[k]);
      end
      wr(6'h10, 8'h55);
      check("unmapped write", rsp, `DALCMP_RESP_SLVERR);
      rdreg(6'h10);
      check("unmapped data", rd, 32'h0);
      check("unmapped read", rsp, `DALCMP_RESP_SLVERR);
      wr(`DALCMP_IDX_A0_SEC, 8'h42);
      w_strb <= 4'h0;
      wr(`DALCMP_IDX_A0_SEC, 8'h11);
      w_strb <= 4'hF;
      expect_reg(`DALCMP_IDX_A0_SEC, 8'h42);
      // each non-reserved select code against single fields and the full set, units alternating
      for (int i = 0; i < 6; i++)
      begin
         u = i % 2;
         base = u ? `DALCMP_IDX_A1_SEC : `DALCMP_IDX_A0_SEC;
         mv = '{bcd(5), bcd(5), bcd(2), 8'(1 + i), bcd(3), bcd(1)};
         for (k = 0; k < 6; k++)
            if (k != 3)
               wr(base + 6'(k), mv[k]);
         for (int j = 0; j < 8; j++)
         begin
            v = {2'b00, j > 5 ? (j == 6 ? 6'h1F : 6'h3F) : 6'(1 << j)};
            put_time(6'h00);
            wr(base + 6'h3, {1'b0, codes[i], 1'b0, mv[3][2:0]});
            check("flag cleared", flags[u], 1'b0);
            put_time(v[5:0]);
            tick(2);
            check("match flag", flags[u], exp_flag(codes[i], v[5:0]));
         end
         put_time(6'h00);
         tick(2);
         check("sticky flag", flags[u], 1'b1);
      end
      // twelve hour compare with afternoon bit; format bit mirrored
      mv[2] = 8'h52;
      wr(`DALCMP_IDX_A0_HOUR, 8'h32);
      put_time(6'h04);
      wr(`DALCMP_IDX_A0_WKDAY, 8'h21);
      expect_reg(`DALCMP_IDX_A0_HOUR, 8'h72);
      check("morning no match", flags[0], 1'b0);
      mv[2] = 8'h72;
      put_time(6'h04);
      tick(2);
      check("afternoon match", flags[0], 1'b1);
      wr(`DALCMP_IDX_A0_WKDAY, 8'h29);
      check("flag set again", flags[0], 1'b1);
      put_time(6'h00);
      wr(`DALCMP_IDX_A0_WKDAY, 8'h29);
      check("flag not writable", flags[0], 1'b0);
      expect_reg(`DALCMP_IDX_A0_WKDAY, 8'h21);
      // pin mux over enables, polarity and flag pairs
      wr(`DALCMP_IDX_A0_SEC, 8'h10);
      wr(`DALCMP_IDX_A1_SEC, 8'h20);
      for (int e = 0; e < 4; e++)
         for (int p = 0; p < 2; p++)
            for (int f = 0; f < 4; f++)
            begin
               wr(`DALCMP_IDX_A0_WKDAY, {p[0], 7'h01});
               wr(`DALCMP_IDX_A1_WKDAY, {p[0], 7'h01});
               @(posedge mclk);
               cur_s <= f[0] ? 8'h10 : 8'h7F;
               @(posedge mclk);
               cur_s <= f[1] ? 8'h20 : 8'h7F;
               @(posedge mclk);
               cur_s <= 8'h7F;
               wr(`DALCMP_IDX_CTRL, {p[0], 1'b0, e[1:0], 4'h0});
               tick(3);
               check("flag pair", flags, f[1:0]);
               v = {7'h00, exp_pin(e[1:0], p[0], f[1:0], p[0])};
               check("pin level", !pin_oe, v);
            end
      wr(`DALCMP_IDX_CTRL, 8'h70);
      for (int l = 0; l < 2; l++)
      begin
         @(posedge mclk);
         sq_lvl <= l[0];
         tick(3);
         check("square wave pin", !pin_oe, l[0]);
      end
      give_verdict();
   end
endmodule

// *** dalcmp_top.sv ***
// dual alarm comparator with AXI4-Lite register slave and output pin mux
`include "dalcmp_defines.svh"

// How it works
// [RULE1] two identical independent alarm units
// [RULE2] hardware sets flag when selected fields match
// [RULE3] select code picks compared fields
// [RULE4] software never writes reserved codes 101, 110
// [RULE5] hours compare honours 12/24 hour format
// [RULE6] flag sticky; re-set while match persists
// [RULE7] flag not writable; weekday write clears it
// [RULE8] enabled alarm, no square wave: pin interrupts
// [RULE9] polarity bit sets asserted pin level
// [RULE10] values kept as BCD; unused bits zero
// [RULE11] seconds/minutes: tens 6-4, ones 3-0
// [RULE12] hours bit 6 mirrors timekeeping format
// [RULE13] hours: pm bit 5 or tens 5-4
// [RULE14] weekday bits 2-0 hold day 1..7
// [RULE15] date: tens 5-4, ones 3-0
// [RULE16] month: tens bit 4, ones 3-0
// [RULE17] software loads only valid BCD
// [RULE18] software follows the configuration order
// [RULE19] control bits 5 and 4 enable units
// [RULE20] one enabled: pin is flag or inverse
// [RULE21] both enabled: OR, or inverted AND
// [RULE22] compare tracks counters; disabled unit off pin
module dalcmp_top
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   // AXI4-Lite write channels
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // current timekeeping values
   input  wire dalcmp_pkg::dalcmp_byte_t cur_seconds,
   input  wire dalcmp_pkg::dalcmp_byte_t cur_minutes,
   input  wire dalcmp_pkg::dalcmp_byte_t timekeeping_hours_reg,
   input  wire dalcmp_pkg::dalcmp_byte_t cur_weekday,
   input  wire dalcmp_pkg::dalcmp_byte_t cur_date,
   input  wire dalcmp_pkg::dalcmp_byte_t cur_month,
   input  wire logic                  square_wave_level,
   // flags and open-drain multi_function_pin
   output logic [1:0]                 alarm_match_flag,
   output logic                       multi_function_pin_o,
   output logic                       multi_function_pin_oe
);
   import dalcmp_pkg::*;

   localparam int NU = 2;

   logic [6:0]        sec_q [NU];
   logic [6:0]        min_q [NU];
   logic [5:0]        hour_q [NU];
   logic [2:0]        wkday_q [NU];
   dalcmp_match_sel_t sel_q [NU];
   logic [5:0]        date_q [NU];
   logic [4:0]        mth_q [NU];
   logic [1:0]        flag_q;
   logic              pol_q;
   logic              gpo_q;
   logic              sqw_en_q;
   logic [1:0]        en_q;
   logic [1:0]        match;
   logic [1:0]        wk_wr;
   logic              mfp_q;
   logic              mfp_d;

   logic              aw_full_q;
   logic [5:0]        aw_idx_q;
   logic              w_full_q;
   logic [7:0]        w_data_q;
   logic              w_lane_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;
   logic              wr_fire;
   logic              wr_en;

   // index of field f (0 sec .. 5 month) of unit u
   function automatic logic [5:0] reg_idx(input int u, input int f);
      logic [5:0] r;
      r = 6'h00;
      case (f)
         0: r = (u == 0) ? `DALCMP_IDX_A0_SEC : `DALCMP_IDX_A1_SEC;
         1: r = (u == 0) ? `DALCMP_IDX_A0_MIN : `DALCMP_IDX_A1_MIN;
         2: r = (u == 0) ? `DALCMP_IDX_A0_HOUR : `DALCMP_IDX_A1_HOUR;
         3: r = (u == 0) ? `DALCMP_IDX_A0_WKDAY : `DALCMP_IDX_A1_WKDAY;
         4: r = (u == 0) ? `DALCMP_IDX_A0_DATE : `DALCMP_IDX_A1_DATE;
         default: r = (u == 0) ? `DALCMP_IDX_A0_MTH : `DALCMP_IDX_A1_MTH;
      endcase
      return r;
   endfunction

   function automatic logic reg_hit(input logic [5:0] idx);
      logic h;
      h = (idx == `DALCMP_IDX_CTRL);
      for (int u = 0; u < NU; u++)
         for (int f = 0; f < 6; f++)
            h = h | (idx == reg_idx(u, f));
      return h;
   endfunction

   // 12-hour: pm flag plus one tens bit; 24-hour: two tens bits
   function automatic logic hour_eq(input logic [5:0] a, input dalcmp_byte_t cur);
      if (cur[`DALCMP_HR_FMT_BIT])
         return (a[`DALCMP_HR_PM_BIT] == cur[`DALCMP_HR_PM_BIT]) && (a[4:0] == cur[4:0]); // [RULE5]
      else
         return (a[5:4] == cur[5:4]) && (a[3:0] == cur[3:0]); // [RULE5]
   endfunction

   // read value; bit 6 of hours is the live format bit
   function automatic dalcmp_byte_t rd_mux(input logic [5:0] idx);
      dalcmp_byte_t v;
      v = 8'h00;
      if (idx == `DALCMP_IDX_CTRL)
         v = {gpo_q, sqw_en_q, en_q[1], en_q[0], 4'h0};
      for (int u = 0; u < NU; u++)
      begin
         if (idx == reg_idx(u, 0)) v = {1'b0, sec_q[u]}; // [RULE11]
         if (idx == reg_idx(u, 1)) v = {1'b0, min_q[u]}; // [RULE11]
         if (idx == reg_idx(u, 2))
            v = {1'b0, timekeeping_hours_reg[`DALCMP_HR_FMT_BIT], hour_q[u]}; // [RULE12]
         if (idx == reg_idx(u, 3))
            v = {pol_q, sel_q[u], flag_q[u], wkday_q[u]}; // [RULE14]
         if (idx == reg_idx(u, 4)) v = {2'b00, date_q[u]}; // [RULE15]
         if (idx == reg_idx(u, 5)) v = {3'b000, mth_q[u]}; // [RULE16]
      end
      return v;
   endfunction

   // write address and data are taken independently
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready  = ~w_full_q;
   assign wr_fire       = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_en         = wr_fire & w_lane_q & reg_hit(aw_idx_q);

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_full_q <= 1'b0;
         aw_idx_q  <= 6'h00;
      end
      else if (s_axi_awvalid && !aw_full_q)
      begin
         aw_full_q <= 1'b1;
         aw_idx_q  <= s_axi_awaddr[7:2];
      end
      else if (wr_fire)
         aw_full_q <= 1'b0;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         w_full_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
      end
      else if (s_axi_wvalid && !w_full_q)
      begin
         w_full_q <= 1'b1;
         w_data_q <= s_axi_wdata[7:0];
         w_lane_q <= s_axi_wstrb[0];
      end
      else if (wr_fire)
         w_full_q <= 1'b0;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= `DALCMP_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= reg_hit(aw_idx_q) ? `DALCMP_RESP_OKAY : `DALCMP_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= `DALCMP_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= reg_hit(s_axi_araddr[7:2]) ? `DALCMP_RESP_OKAY : `DALCMP_RESP_SLVERR;
         rdata_q  <= {24'h00_0000, rd_mux(s_axi_araddr[7:2])}; // [RULE10]
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // control register
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         gpo_q    <= `DALCMP_RST_GPO;
         sqw_en_q <= 1'b0;
         en_q     <= 2'b00;
      end
      else if (wr_en && aw_idx_q == `DALCMP_IDX_CTRL)
      begin
         gpo_q    <= w_data_q[`DALCMP_CTRL_GPO_BIT];
         sqw_en_q <= w_data_q[`DALCMP_CTRL_SQW_BIT];
         en_q     <= {w_data_q[`DALCMP_CTRL_EN1_BIT], w_data_q[`DALCMP_CTRL_EN0_BIT]}; // [RULE19]
      end
   end

   // polarity is one shared bit, seen in both weekday registers
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         pol_q <= 1'b0;
      else if (wk_wr != 2'b00)
         pol_q <= w_data_q[`DALCMP_WK_POL_BIT]; // [RULE9]
   end

   // per-unit match values, unused bits never stored
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int u = 0; u < NU; u++)
         begin
            sec_q[u]   <= 7'h00;
            min_q[u]   <= 7'h00;
            hour_q[u]  <= 6'h00;
            wkday_q[u] <= `DALCMP_RST_WKDAY;
            sel_q[u]   <= DALCMP_SEL_SEC;
            date_q[u]  <= `DALCMP_RST_DATE;
            mth_q[u]   <= `DALCMP_RST_MTH;
         end
      end
      else if (wr_en)
      begin
         for (int u = 0; u < NU; u++) // [RULE1]
         begin
            if (aw_idx_q == reg_idx(u, 0)) sec_q[u] <= w_data_q[6:0]; // [RULE11]
            if (aw_idx_q == reg_idx(u, 1)) min_q[u] <= w_data_q[6:0]; // [RULE11]
            if (aw_idx_q == reg_idx(u, 2)) hour_q[u] <= w_data_q[5:0]; // [RULE13]
            if (aw_idx_q == reg_idx(u, 3))
            begin
               wkday_q[u] <= w_data_q[2:0]; // [RULE14]
               sel_q[u]   <= dalcmp_match_sel_t'(w_data_q[`DALCMP_WK_SEL_HI:`DALCMP_WK_SEL_LO]);
            end
            if (aw_idx_q == reg_idx(u, 4)) date_q[u] <= w_data_q[5:0]; // [RULE15]
            if (aw_idx_q == reg_idx(u, 5)) mth_q[u] <= w_data_q[4:0]; // [RULE16]
         end
      end
   end

   // continuous compare follows every counter update
   always_comb
   begin
      logic s_eq;
      logic m_eq;
      logic h_eq;
      logic w_eq;
      logic d_eq;
      logic mo_eq;
      s_eq  = 1'b0;
      m_eq  = 1'b0;
      h_eq  = 1'b0;
      w_eq  = 1'b0;
      d_eq  = 1'b0;
      mo_eq = 1'b0;
      match = 2'b00;
      wk_wr = 2'b00;
      for (int u = 0; u < NU; u++)
      begin
         wk_wr[u] = wr_en && (aw_idx_q == reg_idx(u, 3));
         s_eq     = sec_q[u] == cur_seconds[6:0]; // [RULE10]
         m_eq     = min_q[u] == cur_minutes[6:0];
         h_eq     = hour_eq(hour_q[u], timekeeping_hours_reg);
         w_eq     = wkday_q[u] == cur_weekday[2:0];
         d_eq     = date_q[u] == cur_date[5:0];
         mo_eq    = mth_q[u] == cur_month[4:0];
         unique case (sel_q[u]) // [RULE3] [RULE22]
            DALCMP_SEL_SEC:   match[u] = s_eq;
            DALCMP_SEL_MIN:   match[u] = m_eq;
            DALCMP_SEL_HOUR:  match[u] = h_eq;
            DALCMP_SEL_WKDAY: match[u] = w_eq;
            DALCMP_SEL_DATE:  match[u] = d_eq;
            DALCMP_SEL_ALL:   match[u] = s_eq & m_eq & h_eq & w_eq & d_eq & mo_eq;
            // reserved codes never match
            default:          match[u] = 1'b0;
         endcase
      end
   end

   // set wins over the clearing write, so a held match re-arms at once
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         flag_q <= 2'b00;
      else
         flag_q <= match | (flag_q & ~wk_wr); // [RULE2] [RULE6] [RULE7]
   end

   assign alarm_match_flag = flag_q;

   // pin mux; disabled units are masked out of the pin only
   always_comb
   begin
      dalcmp_out_mode_t mode;
      logic [1:0]       live;
      live = flag_q & en_q; // [RULE22]
      mode = DALCMP_OUT_GPO;
      if (sqw_en_q)
         mode = DALCMP_OUT_SQW;
      else if (en_q != 2'b00)
         mode = DALCMP_OUT_ALARM; // [RULE8]
      else
         mode = DALCMP_OUT_GPO;
      unique case (mode)
         DALCMP_OUT_SQW:   mfp_d = square_wave_level;
         DALCMP_OUT_ALARM:
            if (pol_q)
               mfp_d = |live; // [RULE20] [RULE21]
            else if (en_q == 2'b11)
               mfp_d = ~&flag_q; // [RULE21]
            else
               mfp_d = ~|live; // [RULE20]
         DALCMP_OUT_GPO:   mfp_d = gpo_q;
         default:          mfp_d = gpo_q;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         mfp_q <= `DALCMP_RST_GPO;
      else
         mfp_q <= mfp_d;
   end

   // open drain: only ever pulls low
   assign multi_function_pin_o  = 1'b0;
   assign multi_function_pin_oe = ~mfp_q;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   logic single0_exp;
   logic dual_or_exp;
   logic dual_and_exp;
   assign single0_exp  = pol_q ? flag_q[0] : ~flag_q[0];
   assign dual_or_exp  = |flag_q;
   assign dual_and_exp = ~&flag_q;

   chk_flag_on_match: assert property (match[0] |=> flag_q[0]) // [RULE2]
      else $error("flag 0 not set after match");
   chk_flag_sticky: assert property (flag_q[1] && !wk_wr[1] |=> flag_q[1]) // [RULE6]
      else $error("flag 1 dropped without a clearing write");
   chk_rearm_held: assert property (wk_wr[0] && match[0] |=> flag_q[0]) // [RULE6]
      else $error("flag 0 lost while match held");
   chk_write_clears: assert property (wk_wr[0] && !match[0] |=> !flag_q[0]) // [RULE7]
      else $error("weekday write did not clear flag 0");
   chk_no_sw_set: assert property ($rose(flag_q[1]) |-> $past(match[1])) // [RULE7]
      else $error("flag 1 set without a match");
   chk_seconds_select: assert property
      (sel_q[0] == DALCMP_SEL_SEC && sec_q[0] == cur_seconds[6:0] |-> match[0]) // [RULE3]
      else $error("seconds select missed equal seconds");
   chk_square_wave: assert property (sqw_en_q |=> mfp_q == $past(square_wave_level)) // [RULE8]
      else $error("square wave mode not on pin");
   chk_single_level: assert property
      (!sqw_en_q && en_q == 2'b01 |=> mfp_q == $past(single0_exp)) // [RULE20]
      else $error("single alarm pin level wrong");
   chk_dual_or: assert property
      (!sqw_en_q && en_q == 2'b11 && pol_q |=> mfp_q == $past(dual_or_exp)) // [RULE21]
      else $error("dual alarm OR level wrong");
   chk_dual_and: assert property
      (!sqw_en_q && en_q == 2'b11 && !pol_q |=> mfp_q == $past(dual_and_exp)) // [RULE21]
      else $error("dual alarm inverted AND level wrong");
   chk_read_upper_zero: assert property // [RULE10]
      (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");

   cov_flag0_set: cover property ($rose(flag_q[0]));
   cov_both_flags: cover property (flag_q == 2'b11 && en_q == 2'b11);
   cov_rearm: cover property (wk_wr[0] && match[0]);
   cov_pin_asserted: cover property (en_q != 2'b00 && !sqw_en_q && mfp_q == pol_q);

endmodule
